// ---- airc_consts.svh ----
// Constants for the accelerometer interrupt routing block.
// Assumes inclusion by bare name from the package and design files.
`ifndef AIRC_CONSTS_SVH
`define AIRC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AIRC_OFS_IRQ_SOURCE 8'h0C
`define AIRC_OFS_WAKE_PIN_CTRL 8'h2C
`define AIRC_OFS_SRC_ENABLES 8'h2D
`define AIRC_OFS_PIN_ROUTING 8'h2E

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define AIRC_RST_WAKE_PIN_CTRL 8'h00
`define AIRC_RST_SRC_ENABLES 8'h00
`define AIRC_RST_PIN_ROUTING 8'h00
`define AIRC_MASK_WAKE_PIN_CTRL 8'h7B
`define AIRC_MASK_SOURCES 8'hBD
`define AIRC_MASK_WAKE_GATED 8'h3C
`define AIRC_READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Field positions, wake and pin control register
// ----------------------------------------------------------------
`define AIRC_BIT_WAKE_TRANSIENT 6
`define AIRC_BIT_WAKE_ORIENT 5
`define AIRC_BIT_WAKE_PULSE 4
`define AIRC_BIT_WAKE_FALL 3
`define AIRC_BIT_IRQ_POLARITY 1
`define AIRC_BIT_IRQ_DRIVE 0

// ----------------------------------------------------------------
// Source positions, shared by enables, routing and source register
// ----------------------------------------------------------------
`define AIRC_SRC_SLEEP_WAKE 7
`define AIRC_SRC_TRANSIENT 5
`define AIRC_SRC_ORIENT 4
`define AIRC_SRC_PULSE 3
`define AIRC_SRC_FALL 2
`define AIRC_SRC_SAMPLE 0

// ----------------------------------------------------------------
// Pin levels
// ----------------------------------------------------------------
`define AIRC_PIN_RST_LEVEL 1'b1
`define AIRC_PIN_RST_OE 1'b1

`endif

// ---- airc_pkg.sv ----
// Types for the accelerometer interrupt routing block.
// Assumes airc_consts.svh is on the include path.
`include "airc_consts.svh"

package airc_pkg;

  // Event flags, held as levels by the functional blocks
  typedef struct packed {
    logic sleep_wake;
    logic transient;
    logic orientation;
    logic pulse;
    logic fall_motion;
    logic sample_ready;
  } airc_events_t;

  // Register access from the serial interface
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } airc_reg_req_t;

  // Pin pad controls
  typedef struct packed {
    logic level;
    logic oe;
  } airc_pad_t;

  // Which register an access hits
  typedef enum logic [2:0] {
    AIRC_SEL_NONE = 3'b000,
    AIRC_SEL_SOURCE = 3'b001,
    AIRC_SEL_WAKE_PIN = 3'b010,
    AIRC_SEL_ENABLES = 3'b011,
    AIRC_SEL_ROUTING = 3'b100
  } airc_sel_t;

endpackage

// ---- airc_pin_drv.sv ----
// One interrupt pad driver with programmable polarity and drive type.
// Assumes active, polarity and drive type come from the same clock domain.
`timescale 1ns/1ps
`include "airc_consts.svh"

module airc_pin_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic active,
  input wire logic polarity,
  input wire logic open_drain,
  // Pad
  output airc_pkg::airc_pad_t pad
);
  import airc_pkg::*;

  airc_pad_t pad_ff;
  airc_pad_t nxt_pad;
  wire logic asserted_level;

  assign asserted_level = polarity;

  always_comb begin
    if (open_drain) begin
      nxt_pad.level = asserted_level;
      nxt_pad.oe = active;
    end else begin
      nxt_pad.level = active ? asserted_level : ~asserted_level;
      nxt_pad.oe = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_ff.level <= `AIRC_PIN_RST_LEVEL;
      pad_ff.oe <= `AIRC_PIN_RST_OE;
    end else begin
      pad_ff <= nxt_pad;
    end
  end

  assign pad = pad_ff;

endmodule

// ---- airc_top.sv ----
// Interrupt enable, routing, wake gating and pad control of the accelerometer.
// Assumes event flags, sleep state and auto-sleep enable are synchronous to clk,
// and register accesses arrive as single-cycle strobes from the serial interface.
//
// Functional notes
// - Transient wake bit 6: zero ignores transient in sleep, one lets it wake.
// - Orientation wake bit 5: zero bypasses orientation asleep, one lets it wake.
// - Pulse wake bit 4: zero bypasses pulse in sleep, one lets it wake.
// - Fall/motion wake bit 3: zero bypasses it in sleep, one lets it wake.
// - Polarity bit 1, reset zero: zero means active low, one active high.
// - Drive bit 0, reset zero: zero push-pull, one open drain.
// - Event flags reach routing only while the block's enable bit is set.
// - Sleep/wake enable is enable bit 7, reset zero.
// - Transient enable is enable bit 5, reset zero.
// - Orientation enable is enable bit 4, reset zero.
// - Pulse enable is enable bit 3, reset zero.
// - Fall/motion enable is enable bit 2, reset zero.
// - Sample-ready enable is enable bit 0, reset zero.
// - Routing bit one selects first pin, zero (reset) second pin.
// - Any number of routed sources may assert one pin together.
// - Open drain suits several outputs sharing one wired line.
// - Wake bits matter only while auto-sleep is enabled; it resets off.
`timescale 1ns/1ps
`include "airc_consts.svh"

module airc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access
  input airc_pkg::airc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Functional block events and sleep state
  input airc_pkg::airc_events_t events,
  input wire logic auto_sleep_enable,
  input wire logic in_sleep,
  // Wake request to the sleep sequencer
  output logic wake_request,
  // First interrupt pin
  output logic irq_pin_first_o,
  output logic irq_pin_first_oe,
  // Second interrupt pin
  output logic irq_pin_second_o,
  output logic irq_pin_second_oe
);
  import airc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  wire logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [7:0] wake_and_pin_control_ff;
  logic [7:0] irq_source_enables_ff;
  logic [7:0] irq_pin_routing_ff;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  wire airc_sel_t sel;
  wire logic wr_wake_pin;
  wire logic wr_enables;
  wire logic wr_routing;
  wire logic [7:0] nxt_wake_and_pin_control;
  wire logic [7:0] nxt_irq_source_enables;
  wire logic [7:0] nxt_irq_pin_routing;
  wire logic [7:0] nxt_reg_rdata;

  assign sel = (reg_req.addr == `AIRC_OFS_IRQ_SOURCE) ? AIRC_SEL_SOURCE :
               (reg_req.addr == `AIRC_OFS_WAKE_PIN_CTRL) ? AIRC_SEL_WAKE_PIN :
               (reg_req.addr == `AIRC_OFS_SRC_ENABLES) ? AIRC_SEL_ENABLES :
               (reg_req.addr == `AIRC_OFS_PIN_ROUTING) ? AIRC_SEL_ROUTING :
               AIRC_SEL_NONE;

  assign wr_wake_pin = reg_req.wr_en && (sel == AIRC_SEL_WAKE_PIN);
  assign wr_enables = reg_req.wr_en && (sel == AIRC_SEL_ENABLES);
  assign wr_routing = reg_req.wr_en && (sel == AIRC_SEL_ROUTING);

  // Reserved bits stay zero
  assign nxt_wake_and_pin_control = wr_wake_pin ?
    (reg_req.wdata & `AIRC_MASK_WAKE_PIN_CTRL) : wake_and_pin_control_ff;
  assign nxt_irq_source_enables = wr_enables ?
    (reg_req.wdata & `AIRC_MASK_SOURCES) : irq_source_enables_ff;
  assign nxt_irq_pin_routing = wr_routing ?
    (reg_req.wdata & `AIRC_MASK_SOURCES) : irq_pin_routing_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_and_pin_control_ff <= `AIRC_RST_WAKE_PIN_CTRL;
      irq_source_enables_ff <= `AIRC_RST_SRC_ENABLES;
      irq_pin_routing_ff <= `AIRC_RST_PIN_ROUTING;
    end else begin
      wake_and_pin_control_ff <= nxt_wake_and_pin_control;
      irq_source_enables_ff <= nxt_irq_source_enables;
      irq_pin_routing_ff <= nxt_irq_pin_routing;
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire logic wake_on_transient;
  wire logic wake_on_orientation;
  wire logic wake_on_pulse;
  wire logic wake_on_fall_motion;
  wire logic irq_polarity;
  wire logic irq_drive_type;

  assign wake_on_transient = wake_and_pin_control_ff[`AIRC_BIT_WAKE_TRANSIENT];
  assign wake_on_orientation = wake_and_pin_control_ff[`AIRC_BIT_WAKE_ORIENT];
  assign wake_on_pulse = wake_and_pin_control_ff[`AIRC_BIT_WAKE_PULSE];
  assign wake_on_fall_motion = wake_and_pin_control_ff[`AIRC_BIT_WAKE_FALL];
  assign irq_polarity = wake_and_pin_control_ff[`AIRC_BIT_IRQ_POLARITY];
  assign irq_drive_type = wake_and_pin_control_ff[`AIRC_BIT_IRQ_DRIVE];

  // ----------------------------------------------------------------
  // Enable fields
  // ----------------------------------------------------------------
  wire logic ien_sleep_wake;
  wire logic ien_transient;
  wire logic ien_orientation;
  wire logic ien_pulse;
  wire logic ien_fall_motion;
  wire logic ien_sample_ready;

  assign ien_sleep_wake = irq_source_enables_ff[`AIRC_SRC_SLEEP_WAKE];
  assign ien_transient = irq_source_enables_ff[`AIRC_SRC_TRANSIENT];
  assign ien_orientation = irq_source_enables_ff[`AIRC_SRC_ORIENT];
  assign ien_pulse = irq_source_enables_ff[`AIRC_SRC_PULSE];
  assign ien_fall_motion = irq_source_enables_ff[`AIRC_SRC_FALL];
  assign ien_sample_ready = irq_source_enables_ff[`AIRC_SRC_SAMPLE];

  // ----------------------------------------------------------------
  // Routing fields
  // ----------------------------------------------------------------
  wire logic route_sleep_wake;
  wire logic route_transient;
  wire logic route_orientation;
  wire logic route_pulse;
  wire logic route_fall_motion;
  wire logic route_sample_ready;
  logic [7:0] to_first;

  assign route_sleep_wake = irq_pin_routing_ff[`AIRC_SRC_SLEEP_WAKE];
  assign route_transient = irq_pin_routing_ff[`AIRC_SRC_TRANSIENT];
  assign route_orientation = irq_pin_routing_ff[`AIRC_SRC_ORIENT];
  assign route_pulse = irq_pin_routing_ff[`AIRC_SRC_PULSE];
  assign route_fall_motion = irq_pin_routing_ff[`AIRC_SRC_FALL];
  assign route_sample_ready = irq_pin_routing_ff[`AIRC_SRC_SAMPLE];

  // Set bit steers a source to the first pin
  always_comb begin
    to_first = 8'h00;
    to_first[`AIRC_SRC_SLEEP_WAKE] = route_sleep_wake;
    to_first[`AIRC_SRC_TRANSIENT] = route_transient;
    to_first[`AIRC_SRC_ORIENT] = route_orientation;
    to_first[`AIRC_SRC_PULSE] = route_pulse;
    to_first[`AIRC_SRC_FALL] = route_fall_motion;
    to_first[`AIRC_SRC_SAMPLE] = route_sample_ready;
  end

  // ----------------------------------------------------------------
  // Source vector
  // ----------------------------------------------------------------
  logic [7:0] gated_src;
  wire logic [7:0] enabled_src;
  wire logic [7:0] wake_mask;
  wire logic [7:0] bypass_mask;
  wire logic [7:0] live_src;
  wire logic sleeping;

  always_comb begin
    gated_src = 8'h00;
    gated_src[`AIRC_SRC_SLEEP_WAKE] = events.sleep_wake && ien_sleep_wake;
    gated_src[`AIRC_SRC_TRANSIENT] = events.transient && ien_transient;
    gated_src[`AIRC_SRC_ORIENT] = events.orientation && ien_orientation;
    gated_src[`AIRC_SRC_PULSE] = events.pulse && ien_pulse;
    gated_src[`AIRC_SRC_FALL] = events.fall_motion && ien_fall_motion;
    gated_src[`AIRC_SRC_SAMPLE] = events.sample_ready && ien_sample_ready;
  end

  assign enabled_src = gated_src;

  // ----------------------------------------------------------------
  // Sleep bypass and wake
  // ----------------------------------------------------------------
  // only with auto-sleep
  assign sleeping = auto_sleep_enable && in_sleep;

  assign wake_mask = {2'b00,
                      wake_on_transient,
                      wake_on_orientation,
                      wake_on_pulse,
                      wake_on_fall_motion,
                      2'b00};

  // Sleep/wake and sample-ready never bypassed
  assign bypass_mask = sleeping ? (`AIRC_MASK_WAKE_GATED & ~wake_mask) : 8'h00;
  assign live_src = enabled_src & ~bypass_mask;

  logic wake_request_ff;
  wire logic nxt_wake_request;

  assign nxt_wake_request = sleeping && (|(enabled_src & wake_mask));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request_ff <= 1'b0;
    end else begin
      wake_request_ff <= nxt_wake_request;
    end
  end

  assign wake_request = wake_request_ff;

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  wire logic [7:0] first_src;
  wire logic [7:0] second_src;
  wire logic first_active;
  wire logic second_active;

  assign first_src = live_src & to_first;
  assign second_src = live_src & ~to_first;
  assign first_active = |first_src;
  assign second_active = |second_src;

  airc_pad_t pad_first;
  airc_pad_t pad_second;

  airc_pin_drv u_pin_first (
    .clk(clk),
    .rst_n(rst_n),
    .active(first_active),
    .polarity(irq_polarity),
    .open_drain(irq_drive_type),
    .pad(pad_first)
  );

  airc_pin_drv u_pin_second (
    .clk(clk),
    .rst_n(rst_n),
    .active(second_active),
    .polarity(irq_polarity),
    .open_drain(irq_drive_type),
    .pad(pad_second)
  );

  assign irq_pin_first_o = pad_first.level;
  assign irq_pin_first_oe = pad_first.oe;
  assign irq_pin_second_o = pad_second.level;
  assign irq_pin_second_oe = pad_second.oe;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // source register view
  assign nxt_reg_rdata = (sel == AIRC_SEL_SOURCE) ? enabled_src :
                         (sel == AIRC_SEL_WAKE_PIN) ? wake_and_pin_control_ff :
                         (sel == AIRC_SEL_ENABLES) ? irq_source_enables_ff :
                         (sel == AIRC_SEL_ROUTING) ? irq_pin_routing_ff :
                         `AIRC_READ_UNMAPPED;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= `AIRC_READ_UNMAPPED;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        reg_rdata_ff <= nxt_reg_rdata;
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;

endmodule

// ---- airc_top_chk.sv ----
// Checker for pin routing, wake request and register reads of airc_top.
// Assumes a bind to airc_top; registers are shadowed from observed writes.
`timescale 1ns/1ps
`include "airc_consts.svh"
module airc_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Inputs
  input airc_pkg::airc_reg_req_t reg_req,
  input airc_pkg::airc_events_t events,
  input wire logic auto_sleep_enable,
  input wire logic in_sleep,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic wake_request,
  input wire logic irq_pin_first_o,
  input wire logic irq_pin_first_oe,
  input wire logic irq_pin_second_o,
  input wire logic irq_pin_second_oe
);
  import airc_pkg::*;
  logic [7:0] ctl_ff, en_ff, rt_ff;
  wire logic [7:0] a = reg_req.addr;
  wire logic [7:0] d = reg_req.wdata;
  wire logic [7:0] src = {events.sleep_wake, 1'b0, events.transient, events.orientation,
    events.pulse, events.fall_motion, 1'b0, events.sample_ready};
  wire logic [7:0] wmask = {2'b00, ctl_ff[6:3], 2'b00};
  wire logic sleeping = auto_sleep_enable & in_sleep;
  wire logic [7:0] live = src & en_ff & ~(sleeping ? (8'h3C & ~wmask) : 8'h00);
  wire logic act1 = |(live & rt_ff);
  wire logic act2 = |(live & ~rt_ff);
  wire logic pol = ctl_ff[1];
  wire logic od = ctl_ff[0];
  wire logic wake_c = sleeping & |(src & en_ff & wmask);
  wire logic [7:0] exp_rd = (a == 8'h0C) ? (src & en_ff) : (a == 8'h2C) ? ctl_ff :
    (a == 8'h2D) ? en_ff : (a == 8'h2E) ? rt_ff : 8'h00;
  wire logic wr = reg_req.wr_en;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= 8'h00;
      en_ff <= 8'h00;
      rt_ff <= 8'h00;
    end else begin
      if (wr && a == 8'h2C) ctl_ff <= d & 8'h7B;
      if (wr && a == 8'h2D) en_ff <= d & 8'hBD;
      if (wr && a == 8'h2E) rt_ff <= d & 8'hBD;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  rvalid_timing_a: assert property (
    reg_rvalid == $past(reg_req.rd_en)) else $error("read valid timing wrong");
  read_data_a: assert property (
    reg_rvalid |-> reg_rdata == $past(exp_rd)) else $error("read data wrong");
  first_active_a: assert property (
    $past(act1) |-> irq_pin_first_oe && irq_pin_first_o == $past(pol))
    else $error("first pin not asserted");
  first_idle_a: assert property (
    !$past(act1) && !$past(od) |-> irq_pin_first_oe && irq_pin_first_o != $past(pol))
    else $error("first pin idle level wrong");
  second_active_a: assert property (
    $past(act2) |-> irq_pin_second_oe && irq_pin_second_o == $past(pol))
    else $error("second pin not asserted");
  second_idle_a: assert property (
    !$past(act2) && !$past(od) |-> irq_pin_second_oe && irq_pin_second_o != $past(pol))
    else $error("second pin idle level wrong");
  od_release_a: assert property (
    $past(od) |-> irq_pin_first_oe == $past(act1) && irq_pin_second_oe == $past(act2))
    else $error("open drain pin not released");
  wake_gate_a: assert property (
    wake_request == $past(wake_c)) else $error("wake request wrong");
endmodule

// ---- airc_host_model.sv ----
// Host side: resolves both interrupt wires and flags the asserted ones.
// Assumes a board resistor toward the inactive level on each wire.
`timescale 1ns/1ps
module airc_host_model (
  // Pads
  input wire logic p1_o,
  input wire logic p1_oe,
  input wire logic p2_o,
  input wire logic p2_oe,
  // Active level the host expects
  input wire logic active_high,
  // Seen interrupts
  output logic first_irq,
  output logic second_irq
);
  wire logic w1 = p1_oe ? p1_o : !active_high;
  wire logic w2 = p2_oe ? p2_o : !active_high;
  assign first_irq = (w1 == active_high);
  assign second_irq = (w2 == active_high);
endmodule

// ---- accel_interrupt_routing_ctrl_bench.sv ----
// Bench: table of routing cases, then reserved, read-only and unmapped accesses.
// Assumes airc_consts.svh on the include path.
`timescale 1ns/1ps
`include "airc_consts.svh"
module accel_interrupt_routing_ctrl_bench;
  import airc_pkg::*;
  typedef struct packed {
    logic [7:0] en, rt, cr;
    logic [5:0] ev;
    logic as, sl, f, s, w;
  } airc_row_t;
  logic clk = 0, reset_n = 0, ase = 0, slp = 0, act_hi = 0;
  airc_reg_req_t reg_req = '0;
  airc_events_t events = '0;
  logic [7:0] rdata;
  logic rvalid, wake, p1o, p1oe, p2o, p2oe, f_irq, s_irq;
  int n_errors = 0, check_count = 0;
  airc_row_t rows[16] = '{
    {8'h01, 8'h00, 8'h00, 6'h01, 5'b00010},
    {8'h01, 8'h01, 8'h00, 6'h01, 5'b00100},
    {8'h00, 8'hBD, 8'h00, 6'h3F, 5'b00000},
    {8'h80, 8'h80, 8'h00, 6'h20, 5'b00100},
    {8'h20, 8'h00, 8'h00, 6'h10, 5'b00010},
    {8'h10, 8'h10, 8'h00, 6'h08, 5'b00100},
    {8'h08, 8'h00, 8'h00, 6'h04, 5'b00010},
    {8'h04, 8'h04, 8'h00, 6'h02, 5'b00100},
    {8'hBD, 8'h85, 8'h02, 6'h3F, 5'b00110},
    {8'hBD, 8'hBD, 8'h03, 6'h3F, 5'b00100},
    {8'h3C, 8'h3C, 8'h00, 6'h1E, 5'b11000},
    {8'h3C, 8'h3C, 8'h40, 6'h10, 5'b11101},
    {8'h3C, 8'h3C, 8'h20, 6'h08, 5'b11101},
    {8'h3C, 8'h3C, 8'h10, 6'h04, 5'b11101},
    {8'h3C, 8'h3C, 8'h08, 6'h02, 5'b11101},
    {8'h3C, 8'h3C, 8'h00, 6'h1E, 5'b01100}};
  always #10 clk = ~clk;
  airc_top i_airc_top (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .events(events), .auto_sleep_enable(ase), .in_sleep(slp),
    .wake_request(wake), .irq_pin_first_o(p1o), .irq_pin_first_oe(p1oe),
    .irq_pin_second_o(p2o), .irq_pin_second_oe(p2oe));
  airc_host_model i_airc_host_model (.p1_o(p1o), .p1_oe(p1oe), .p2_o(p2o), .p2_oe(p2oe),
    .active_high(act_hi), .first_irq(f_irq), .second_irq(s_irq));
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    chk("read valid", {7'h00, rvalid}, 8'h01);
    chk("read data", rdata, exp);
  endtask
  task automatic do_reset();
    @(posedge clk);
    events <= '0;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("first pin pads", {6'h00, p1o, p1oe}, 8'h03);
    chk("wake after reset", {7'h00, wake}, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h2D, 8'h00);
    rd(8'h2E, 8'h00);
    $display("reset test done");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(8'h2C, rows[i].cr);
      wr(8'h2D, rows[i].en);
      wr(8'h2E, rows[i].rt);
      act_hi <= rows[i].cr[1];
      ase <= rows[i].as;
      slp <= rows[i].sl;
      events <= rows[i].ev;
      repeat (3) @(posedge clk);
      #1;
      chk("first pin", {7'h00, f_irq}, {7'h00, rows[i].f});
      chk("second pin", {7'h00, s_irq}, {7'h00, rows[i].s});
      chk("wake", {7'h00, wake}, {7'h00, rows[i].w});
      rd(8'h0C, {rows[i].ev[5], 1'b0, rows[i].ev[4:1], 1'b0, rows[i].ev[0]} & rows[i].en);
      @(posedge clk);
      events <= '0;
      repeat (2) @(posedge clk);
      #1;
      chk("pins released", {6'h00, f_irq, s_irq}, 8'h00);
    end
    $display("table test done");
    @(posedge clk);
    events <= '1;
    wr(8'h2C, 8'hFF);
    rd(8'h2C, 8'h7B);
    wr(8'h2D, 8'hFF);
    rd(8'h2D, 8'hBD);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'hBD);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'hBD);
    rd(8'h2F, 8'h00);
    chk("second pin released", {7'h00, p2oe}, 8'h00);
    $display("access test done");
    do_reset();
    finish_test();
  end
endmodule
bind airc_top airc_top_chk i_airc_top_chk (.clk, .reset_n, .reg_req, .events,
  .auto_sleep_enable, .in_sleep, .reg_rdata, .reg_rvalid, .wake_request, .irq_pin_first_o,
  .irq_pin_first_oe, .irq_pin_second_o, .irq_pin_second_oe);
